// ---- design/srrc_pkg.sv ----
// package: constants and carrier types for speed reference / run command select
package srrc_pkg;
  localparam int SRRC_REF_W          = 16;
  localparam int SRRC_SYS_CLK_MHZ    = 100;
  localparam int SRRC_DEB_TIME_US    = 1000;
  localparam int SRRC_DEB_CYC        = SRRC_DEB_TIME_US * SRRC_SYS_CLK_MHZ;
  localparam int SRRC_HOLD_TIME_MS   = 50;
  localparam int SRRC_HOLD_CYC       =
    SRRC_HOLD_TIME_MS * 1000 * SRRC_SYS_CLK_MHZ;
  localparam int SRRC_STOP_TMR_MS    = 500;
  localparam int SRRC_STOP_TMR_CYC   =
    SRRC_STOP_TMR_MS * 1000 * SRRC_SYS_CLK_MHZ;
  localparam int SRRC_N_MFI          = 10;

  localparam logic [1:0] SRRC_REFSRC_KEYPAD = 2'h0;
  localparam logic [1:0] SRRC_REFSRC_ANALOG = 2'h1;
  localparam logic [1:0] SRRC_RUNSRC_KEYPAD = 2'h0;
  localparam logic [1:0] SRRC_RUNSRC_TERM   = 2'h1;
  localparam logic [1:0] SRRC_RUNSRC_SERIAL = 2'h2;
  localparam logic [1:0] SRRC_RUNSRC_OPTION = 2'h3;
  localparam logic [1:0] SRRC_RUNSRC_RST    = 2'h1;
  localparam logic [1:0] SRRC_STOP_DECEL    = 2'h0;
  localparam logic [1:0] SRRC_STOP_COAST    = 2'h1;
  localparam logic [1:0] SRRC_STOP_DCINJ    = 2'h2;
  localparam logic [1:0] SRRC_STOP_COAST_TMR= 2'h3;
  localparam logic [1:0] SRRC_STOP_RST      = 2'h0;
  localparam logic [4:0] SRRC_AFN_AUX1      = 5'h02;
  localparam logic [4:0] SRRC_AFN_AUX2      = 5'h03;
  localparam logic [4:0] SRRC_AFN_UNUSED    = 5'h1F;
  localparam logic [4:0] SRRC_MFI_3WIRE     = 5'h00;
  localparam int SRRC_INIT_3WIRE_MFI        = 3;

  // contact inputs gathered together
  typedef struct packed {
    logic fwd_run;
    logic rev_run;
    logic step_one;
    logic step_two;
    logic step_three;
    logic jog;
  } srrc_contacts_t;

  // run request from any one source
  typedef struct packed {
    logic run;
    logic rev;
    logic jog;
  } srrc_run_req_t;
endpackage

// ---- design/srrc_debounce.sv ----
// synchroniser and debounce filter for one contact input
`timescale 1ns/1ps
`default_nettype none
module srrc_debounce
  import srrc_pkg::*;
#(
  parameter int DEB_CYC = SRRC_DEB_CYC
) (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic raw_in,
  output logic      clean_q
);
  localparam int CW = $clog2(DEB_CYC + 1);
  logic          meta_q;
  logic          sync_q;
  logic [CW-1:0] cnt_q;
  wire           differs = sync_q != clean_q;
  wire           settled = cnt_q == CW'(DEB_CYC - 1);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q  <= 1'b0;
      sync_q  <= 1'b0;
      cnt_q   <= '0;
      clean_q <= 1'b0;
    end else begin
      meta_q  <= raw_in;
      sync_q  <= meta_q;
      // any bounce restarts the count
      cnt_q   <= (differs && !settled) ? cnt_q + 1'b1 : '0;
      if (differs && settled) clean_q <= sync_q;
    end
  end
endmodule
`default_nettype wire

// ---- design/srrc_ref_mux.sv ----
// speed reference step selection
`timescale 1ns/1ps
`default_nettype none
module srrc_ref_mux
  import srrc_pkg::*;
#(
  parameter int W = SRRC_REF_W
) (
  input  wire logic            sys_clk,
  input  wire logic            rst_b,
  input  wire logic [2:0]      step_idx,
  input  wire logic            jog_sel,
  input  wire logic [1:0]      speed_ref_source_sel,
  input  wire logic [4:0]      analog_two_function,
  input  wire logic [4:0]      analog_three_function,
  input  wire logic [8*W-1:0]  preset_speeds,
  input  wire logic [W-1:0]    jog_preset_speed,
  input  wire logic [W-1:0]    analog_input_one,
  input  wire logic [W-1:0]    analog_input_two,
  input  wire logic [W-1:0]    analog_input_three,
  output logic [W-1:0]         speed_ref_q
);
  wire [W-1:0] preset_sel = preset_speeds[step_idx*W +: W];
  wire use_a1 = speed_ref_source_sel == SRRC_REFSRC_ANALOG;
  wire use_a2 = analog_two_function == SRRC_AFN_AUX1;
  wire use_a3 = analog_three_function == SRRC_AFN_AUX2;
  wire [W-1:0] step_ref =
    (step_idx == 3'h0 && use_a1) ? analog_input_one :
    (step_idx == 3'h1 && use_a2) ? analog_input_two :
    (step_idx == 3'h2 && use_a3) ? analog_input_three : preset_sel;
  wire [W-1:0] ref_d = jog_sel ? jog_preset_speed : step_ref;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) speed_ref_q <= '0;
    else speed_ref_q <= ref_d;
  end

  property p_jog_wins;
    @(posedge sys_clk) disable iff (!rst_b)
    jog_sel |=> speed_ref_q == $past(jog_preset_speed);
  endproperty
  a_jog_wins: assert property (p_jog_wins)
    else $error("jog preset not selected");

  property p_step_eight;
    @(posedge sys_clk) disable iff (!rst_b)
    (!jog_sel && step_idx == 3'h7)
      |=> speed_ref_q == $past(preset_speeds[8*W-1 -: W]);
  endproperty
  a_step_eight: assert property (p_step_eight)
    else $error("step eight preset wrong");

  property p_step_one_a;
    @(posedge sys_clk) disable iff (!rst_b)
    (!jog_sel && step_idx == 3'h0 && use_a1)
      |=> speed_ref_q == $past(analog_input_one);
  endproperty
  a_step_one_a: assert property (p_step_one_a)
    else $error("step one analog wrong");

  property p_step_three;
    @(posedge sys_clk) disable iff (!rst_b)
    (!jog_sel && step_idx == 3'h2 && analog_three_function == SRRC_AFN_UNUSED)
      |=> speed_ref_q == $past(preset_speeds[3*W-1 -: W]);
  endproperty
  a_step_three: assert property (p_step_three)
    else $error("step three preset wrong");

  c_jog: cover property (@(posedge sys_clk) disable iff (!rst_b) jog_sel);
  c_a2:  cover property (@(posedge sys_clk) disable iff (!rst_b)
    step_idx == 3'h1 && use_a2);
endmodule
`default_nettype wire

// ---- design/srrc_top.sv ----
// speed reference and run command selection top
`timescale 1ns/1ps
`default_nettype none
module srrc_top
  import srrc_pkg::*;
#(
  parameter int W         = SRRC_REF_W,
  parameter int N_MFI     = SRRC_N_MFI,
  parameter int DEB_CYC   = SRRC_DEB_CYC,
  parameter int HOLD_CYC  = SRRC_HOLD_CYC,
  parameter int STOP_CYC  = SRRC_STOP_TMR_CYC
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire srrc_contacts_t    contacts_in,
  input  wire logic [N_MFI-1:0]  mfi_raw_in,
  input  wire logic [5*N_MFI-1:0] multifunction_input_functions,
  input  wire logic              init_mode_setting,
  input  wire logic [1:0]        speed_ref_source_sel,
  input  wire logic [1:0]        run_cmd_source_sel,
  input  wire logic [1:0]        stop_method_sel,
  input  wire logic              flux_vector_mode,
  input  wire logic [4:0]        analog_two_function,
  input  wire logic [4:0]        analog_three_function,
  input  wire logic [8*W-1:0]    preset_speeds,
  input  wire logic [W-1:0]      jog_preset_speed,
  input  wire logic [W-1:0]      analog_input_one,
  input  wire logic [W-1:0]      analog_input_two,
  input  wire logic [W-1:0]      analog_input_three,
  input  wire srrc_run_req_t     keypad_req,
  input  wire srrc_run_req_t     serial_req,
  input  wire srrc_run_req_t     option_req,
  output logic [W-1:0]           speed_ref_q,
  output logic                   run_q,
  output logic                   reverse_q,
  output logic                   jog_q,
  output logic [1:0]             stop_method_q,
  output logic                   stopping_q,
  output logic                   three_wire_q
);
  typedef enum logic [2:0] {
    SRRC_ST_IDLE = 3'b001,
    SRRC_ST_RUN  = 3'b010,
    SRRC_ST_STOP = 3'b100
  } srrc_state_t;

  localparam int HW = $clog2(HOLD_CYC + 1);
  localparam int SW = $clog2(STOP_CYC + 1);

  // synchronised contacts
  srrc_contacts_t    ct;
  logic [N_MFI-1:0]  mfi;

  genvar g;
  for (g = 0; g < 6; g++) begin : g_ct
    srrc_debounce #(.DEB_CYC(DEB_CYC)) u_deb (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .raw_in  (contacts_in[g]),
      .clean_q (ct[g])
    );
  end
  for (g = 0; g < N_MFI; g++) begin : g_mfi
    srrc_debounce #(.DEB_CYC(DEB_CYC)) u_deb (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .raw_in  (mfi_raw_in[g]),
      .clean_q (mfi[g])
    );
  end

  // reference path
  srrc_ref_mux #(.W(W)) u_ref (
    .sys_clk               (sys_clk),
    .rst_b                 (rst_b),
    .step_idx              ({ct.step_three, ct.step_two, ct.step_one}),
    .jog_sel               (ct.jog),
    .speed_ref_source_sel  (speed_ref_source_sel),
    .analog_two_function   (analog_two_function),
    .analog_three_function (analog_three_function),
    .preset_speeds         (preset_speeds),
    .jog_preset_speed      (jog_preset_speed),
    .analog_input_one      (analog_input_one),
    .analog_input_two      (analog_input_two),
    .analog_input_three    (analog_input_three),
    .speed_ref_q           (speed_ref_q)
  );

  // three-wire detection: lowest set index wins as direction input
  function automatic logic [N_MFI:0] find_dir(
    input logic [5*N_MFI-1:0] fn,
    input logic [N_MFI-1:0]   lvl
  );
    logic found;
    logic dir;
    found = 1'b0;
    dir   = 1'b0;
    for (int i = N_MFI - 1; i >= 0; i--) begin
      if (fn[i*5 +: 5] == SRRC_MFI_3WIRE) begin
        found = 1'b1;
        dir   = lvl[i];
      end
    end
    return {{(N_MFI - 1){1'b0}}, found, dir};
  endfunction

  wire [N_MFI:0] dir_info   = find_dir(multifunction_input_functions, mfi);
  // init mode forces input 3 (index 0 is input 1)
  wire three_wire = dir_info[1] || init_mode_setting;
  wire dir_in     = init_mode_setting ?
                    mfi[SRRC_INIT_3WIRE_MFI - 1] : dir_info[0];

  // three-wire: fwd input is run pulse, rev input is normally closed stop
  logic [HW-1:0] hold_cnt_q;
  logic          latch_q;
  wire           start_seen = hold_cnt_q == HW'(HOLD_CYC - 1);
  wire           stop_open  = !ct.rev_run;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_cnt_q <= '0;
      latch_q    <= 1'b0;
    end else begin
      hold_cnt_q <= (ct.fwd_run && !start_seen) ? hold_cnt_q + 1'b1 :
                    (ct.fwd_run ? hold_cnt_q : '0);
      if (stop_open || !three_wire) latch_q <= 1'b0;
      else if (start_seen) latch_q <= 1'b1;
    end
  end

  // terminal run request
  srrc_run_req_t term_req;
  wire two_fwd = ct.fwd_run && !ct.rev_run;
  wire two_rev = ct.rev_run && !ct.fwd_run;
  assign term_req.run = three_wire ? latch_q : (two_fwd || two_rev);
  assign term_req.rev = three_wire ? dir_in : two_rev;
  assign term_req.jog = 1'b0;

  // source selection
  srrc_run_req_t sel_req;
  always_comb begin
    unique case (run_cmd_source_sel)
      SRRC_RUNSRC_KEYPAD: sel_req = keypad_req;
      SRRC_RUNSRC_TERM:   sel_req = term_req;
      SRRC_RUNSRC_SERIAL: sel_req = serial_req;
      SRRC_RUNSRC_OPTION: sel_req = option_req;
    endcase
  end

  // flux vector cannot coast or dc brake; fall back to decelerate
  wire bad_fv = flux_vector_mode
                && (stop_method_sel != SRRC_STOP_DECEL);
  wire [1:0] method_d = bad_fv ? SRRC_STOP_DECEL : stop_method_sel;

  srrc_state_t   st_q;
  logic [SW-1:0] stop_cnt_q;
  wire           tmr_done = stop_cnt_q == '0;
  wire           blocked  = (stop_method_q == SRRC_STOP_COAST_TMR)
                            && !tmr_done;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q          <= SRRC_ST_IDLE;
      stop_cnt_q    <= '0;
      run_q         <= 1'b0;
      reverse_q     <= 1'b0;
      jog_q         <= 1'b0;
      stop_method_q <= SRRC_STOP_RST;
      stopping_q    <= 1'b0;
      three_wire_q  <= 1'b0;
    end else begin
      three_wire_q <= three_wire;
      stop_cnt_q   <= tmr_done ? stop_cnt_q : stop_cnt_q - 1'b1;
      unique case (st_q)
        SRRC_ST_IDLE: begin
          if (sel_req.run && !blocked) begin
            st_q      <= SRRC_ST_RUN;
            run_q     <= 1'b1;
            reverse_q <= sel_req.rev;
            jog_q     <= sel_req.jog;
          end
        end
        SRRC_ST_RUN: begin
          reverse_q <= sel_req.rev;
          jog_q     <= sel_req.jog;
          if (!sel_req.run) begin
            st_q          <= SRRC_ST_STOP;
            run_q         <= 1'b0;
            stopping_q    <= 1'b1;
            stop_method_q <= method_d;
            stop_cnt_q    <= SW'(STOP_CYC);
          end
        end
        SRRC_ST_STOP: begin
          // one cycle stop pulse, timer keeps running in idle
          stopping_q <= 1'b0;
          st_q       <= SRRC_ST_IDLE;
        end
      endcase
    end
  end

  property p_fv_no_coast;
    @(posedge sys_clk) disable iff (!rst_b)
    (stopping_q && $past(flux_vector_mode))
      |-> stop_method_q == SRRC_STOP_DECEL;
  endproperty
  a_fv_no_coast: assert property (p_fv_no_coast)
    else $error("flux vector used coast or dc stop");

  property p_method_applied;
    @(posedge sys_clk) disable iff (!rst_b)
    (stopping_q && !$past(flux_vector_mode))
      |-> stop_method_q == $past(stop_method_sel);
  endproperty
  a_method_applied: assert property (p_method_applied)
    else $error("stop method not taken from setting");

  property p_stop_pulse;
    @(posedge sys_clk) disable iff (!rst_b)
    stopping_q |=> !stopping_q && !run_q;
  endproperty
  a_stop_pulse: assert property (p_stop_pulse)
    else $error("stop pulse longer than one cycle");

  property p_timer_block;
    @(posedge sys_clk) disable iff (!rst_b)
    (st_q == SRRC_ST_IDLE && blocked) |=> !run_q;
  endproperty
  a_timer_block: assert property (p_timer_block)
    else $error("run accepted during stop timer");

  property p_two_fwd;
    @(posedge sys_clk) disable iff (!rst_b)
    (st_q == SRRC_ST_IDLE && run_cmd_source_sel == SRRC_RUNSRC_TERM
     && !three_wire && two_fwd && !blocked) |=> run_q && !reverse_q;
  endproperty
  a_two_fwd: assert property (p_two_fwd)
    else $error("two-wire forward not run");

  property p_two_stop;
    @(posedge sys_clk) disable iff (!rst_b)
    (run_q && run_cmd_source_sel == SRRC_RUNSRC_TERM && !three_wire
     && !ct.fwd_run && !ct.rev_run) |=> !run_q ##1 !run_q;
  endproperty
  a_two_stop: assert property (p_two_stop)
    else $error("two-wire stop missed");

  property p_latch_clear;
    @(posedge sys_clk) disable iff (!rst_b)
    (three_wire && stop_open) |=> !latch_q;
  endproperty
  a_latch_clear: assert property (p_latch_clear)
    else $error("latch not cleared on stop");

  property p_latch_set;
    @(posedge sys_clk) disable iff (!rst_b)
    (three_wire && !stop_open && start_seen) |=> latch_q;
  endproperty
  a_latch_set: assert property (p_latch_set)
    else $error("held run not latched");

  property p_keypad;
    @(posedge sys_clk) disable iff (!rst_b)
    (st_q == SRRC_ST_IDLE && run_cmd_source_sel == SRRC_RUNSRC_KEYPAD
     && keypad_req.run && !blocked)
      |=> run_q && jog_q == $past(keypad_req.jog);
  endproperty
  a_keypad: assert property (p_keypad)
    else $error("keypad run ignored");

  property p_serial;
    @(posedge sys_clk) disable iff (!rst_b)
    (st_q == SRRC_ST_IDLE && run_cmd_source_sel == SRRC_RUNSRC_SERIAL
     && serial_req.run && !blocked)
      |=> run_q && reverse_q == $past(serial_req.rev);
  endproperty
  a_serial: assert property (p_serial)
    else $error("serial run ignored");

  property p_three_flag;
    @(posedge sys_clk) disable iff (!rst_b)
    init_mode_setting |=> three_wire_q;
  endproperty
  a_three_flag: assert property (p_three_flag)
    else $error("init mode not three-wire");

  c_run:  cover property (@(posedge sys_clk) disable iff (!rst_b) run_q);
  c_stop: cover property (@(posedge sys_clk) disable iff (!rst_b) stopping_q);
  c_3w:   cover property (@(posedge sys_clk) disable iff (!rst_b) latch_q);
endmodule
`default_nettype wire

// ---- test/srrc_contact_model.sv ----
// contact switches and plc outputs feeding the terminal inputs
`timescale 1ns/1ps
`default_nettype none
module srrc_contact_model
  import srrc_pkg::*;
#(
  parameter int HOLD_CYC = 8
) (
  input  wire logic           sys_clk,
  input  wire srrc_contacts_t want,
  input  wire logic           bounce,
  output srrc_contacts_t      contacts
);
  srrc_contacts_t tgt;
  srrc_contacts_t last;
  srrc_contacts_t prev;
  logic           fwd_was;
  int             chatter;
  int             hold_cnt;
  initial begin
    tgt = '0;
    last = '0;
    prev = '0;
    fwd_was = 1'b0;
    chatter = 0;
    hold_cnt = 0;
    contacts = '0;
  end
  // a run press is stretched past the device's hold plus its filter delay
  // sampled on the rising edge so the bench's falling-edge writes are settled
  always @(posedge sys_clk) begin
    if (want.fwd_run && !fwd_was)
      hold_cnt = HOLD_CYC + 12;
    else if (hold_cnt != 0)
      hold_cnt = hold_cnt - 1;
    fwd_was = want.fwd_run;
    tgt = want;
    tgt.fwd_run = want.fwd_run | (hold_cnt != 0);
    // real contacts ring before settling
    if (tgt != last) begin
      chatter = bounce ? 3 : 0;
      prev = last;
      last = tgt;
    end
    if (chatter != 0)
      chatter = chatter - 1;
    contacts <= chatter[0] ? prev : last;
  end
endmodule
`default_nettype wire

// ---- test/srrc_top_tb.sv ----
// self-checking bench for speed reference and run command selection
`timescale 1ns/1ps
`default_nettype none
module srrc_top_tb
  import srrc_pkg::*;
();
  localparam int W = SRRC_REF_W;
  localparam int N = SRRC_N_MFI;
  logic           sys_clk = 1'b0;
  logic           rst_b = 1'b0;
  srrc_contacts_t want = '0;
  srrc_contacts_t contacts;
  logic           bounce = 1'b0;
  logic [N-1:0]   mfi = '0;
  logic [5*N-1:0] mfn = {N{5'h0F}};
  logic           init3 = 1'b0;
  logic [1:0]     ref_src = 2'h0;
  logic [1:0]     run_src = 2'h1;
  logic [1:0]     stop_sel = 2'h0;
  logic           flux = 1'b0;
  logic [4:0]     afn2 = 5'h1F;
  logic [4:0]     afn3 = 5'h1F;
  logic [8*W-1:0] presets = '0;
  logic [W-1:0]   jog_spd = 16'h0B0B;
  logic [W-1:0]   an1 = 16'hA001;
  logic [W-1:0]   an2 = 16'hA002;
  logic [W-1:0]   an3 = 16'hA003;
  srrc_run_req_t  kreq = '0;
  srrc_run_req_t  sreq = '0;
  srrc_run_req_t  oreq = '0;
  logic [W-1:0]   speed_ref_q;
  logic           run_q;
  logic           reverse_q;
  logic           jog_q;
  logic [1:0]     stop_method_q;
  logic           stopping_q;
  logic           three_wire_q;
  logic [19:0]    rows [10];
  int             fails = 0;
  int             cmp_count = 0;

  always #5 sys_clk = ~sys_clk;

  srrc_contact_model #(.HOLD_CYC(8)) MODEL (.sys_clk(sys_clk), .want(want),
    .bounce(bounce), .contacts(contacts));

  srrc_top #(.DEB_CYC(4), .HOLD_CYC(8), .STOP_CYC(16)) DUT (
    .sys_clk(sys_clk), .rst_b(rst_b), .contacts_in(contacts),
    .mfi_raw_in(mfi), .multifunction_input_functions(mfn),
    .init_mode_setting(init3), .speed_ref_source_sel(ref_src),
    .run_cmd_source_sel(run_src), .stop_method_sel(stop_sel),
    .flux_vector_mode(flux), .analog_two_function(afn2),
    .analog_three_function(afn3), .preset_speeds(presets),
    .jog_preset_speed(jog_spd), .analog_input_one(an1),
    .analog_input_two(an2), .analog_input_three(an3),
    .keypad_req(kreq), .serial_req(sreq), .option_req(oreq),
    .speed_ref_q(speed_ref_q), .run_q(run_q), .reverse_q(reverse_q),
    .jog_q(jog_q), .stop_method_q(stop_method_q),
    .stopping_q(stopping_q), .three_wire_q(three_wire_q));

  function automatic logic [W-1:0] pre(input int k);
    return W'(k * 256 + 17);
  endfunction

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [W-1:0] seen,
                       input logic [W-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // which: 0 waits on run_q, 1 on the stop pulse
  task automatic wait_sig(input int which, input logic v);
    int i;
    i = 0;
    while ((which ? stopping_q : run_q) !== v && i < 120) begin
      cyc(1);
      i++;
    end
    if (i == 120) begin
      fails++;
      tally_and_finish();
    end
  endtask

  task automatic run_stop(input logic [1:0] m, input logic [1:0] em);
    stop_sel = m;
    want.fwd_run = 1'b1;
    wait_sig(0, 1'b1);
    check("reverse_q", W'(reverse_q), '0);
    want.fwd_run = 1'b0;
    wait_sig(1, 1'b1);
    check("run_q", W'(run_q), '0);
    check("stop_method_q", W'(stop_method_q), W'(em));
  endtask

  // three-wire start pulse then stop input opened
  task automatic three_wire(input string nm);
    want.rev_run = 1'b1;
    cyc(16);
    check(nm, W'(three_wire_q), 16'h0001);
    want.fwd_run = 1'b1;
    cyc(1);
    want.fwd_run = 1'b0;
    wait_sig(0, 1'b1);
    cyc(30);
    check("latched", W'(run_q), 16'h0001);
    check("reverse_q", W'(reverse_q), 16'h0001);
    want.rev_run = 1'b0;
    wait_sig(0, 1'b0);
  endtask

  initial begin
    for (int k = 0; k < 8; k++) begin
      presets[k*W +: W] = pre(k + 1);
      rows[k] = {1'b0, 3'(k), pre(k + 1)};
    end
    rows[8] = {4'b1101, 16'h0B0B};
    rows[9] = {4'b1111, 16'h0B0B};
    cyc(4);
    check("reset ref", speed_ref_q, '0);
    cyc(1);
    rst_b = 1'b1;
    for (int r = 0; r < 10; r++) begin
      {want.jog, want.step_three, want.step_two, want.step_one} = rows[r][19:16];
      cyc(16);
      check("speed_ref_q", speed_ref_q, rows[r][15:0]);
    end
    {want.jog, want.step_three, want.step_two, want.step_one} = 4'h0;
    ref_src = 2'h1;
    cyc(16);
    check("analog one", speed_ref_q, 16'hA001);
    an1 = 16'h5A5A;
    cyc(2);
    check("analog one live", speed_ref_q, 16'h5A5A);
    ref_src = 2'h0;
    cyc(4);
    check("preset one", speed_ref_q, pre(1));
    want.step_one = 1'b1;
    afn2 = SRRC_AFN_AUX1;
    cyc(16);
    check("analog two", speed_ref_q, 16'hA002);
    want.step_one = 1'b0;
    want.step_two = 1'b1;
    afn3 = SRRC_AFN_AUX2;
    cyc(16);
    check("analog three", speed_ref_q, 16'hA003);
    afn3 = SRRC_AFN_UNUSED;
    cyc(4);
    check("preset three", speed_ref_q, pre(3));
    // a pulse shorter than the filter must not move the reference
    want.step_one = 1'b1;
    cyc(2);
    want.step_one = 1'b0;
    cyc(16);
    check("glitch", speed_ref_q, pre(3));
    bounce = 1'b1;
    for (int s = 0; s < 4; s++) begin
      if (s != 1) begin
        run_src = 2'(s);
        kreq = (s == 0) ? 3'b111 : 3'b100;
        sreq = (s == 2) ? 3'b111 : 3'b100;
        oreq = (s == 3) ? 3'b111 : 3'b100;
        wait_sig(0, 1'b1);
        check("source rev", W'(reverse_q), 16'h0001);
        check("source jog", W'(jog_q), 16'h0001);
        {kreq, sreq, oreq} = '0;
        wait_sig(0, 1'b0);
        cyc(4);
      end
    end
    run_src = SRRC_RUNSRC_TERM;
    for (int m = 0; m < 4; m++)
      run_stop(2'(m), 2'(m));
    // new press while the coast timer runs is held off until the timer expires
    want.fwd_run = 1'b1;
    cyc(12);
    check("timer run", W'(run_q), '0);
    want.fwd_run = 1'b0;
    cyc(40);
    wait_sig(0, 1'b0);
    cyc(30);
    flux = 1'b1;
    run_stop(SRRC_STOP_COAST, SRRC_STOP_DECEL);
    run_stop(SRRC_STOP_DCINJ, SRRC_STOP_DECEL);
    flux = 1'b0;
    stop_sel = SRRC_STOP_DECEL;
    cyc(4);
    want.rev_run = 1'b1;
    wait_sig(0, 1'b1);
    check("rev run", W'(reverse_q), 16'h0001);
    want.rev_run = 1'b0;
    wait_sig(0, 1'b0);
    cyc(8);
    mfn[5*4 +: 5] = SRRC_MFI_3WIRE;
    mfi[4] = 1'b1;
    three_wire("three wire code");
    mfn = {N{5'h0F}};
    mfi = '0;
    mfi[2] = 1'b1;
    init3 = 1'b1;
    three_wire("three wire init");
    want.rev_run = 1'b1;
    want.fwd_run = 1'b1;
    cyc(1);
    want.fwd_run = 1'b0;
    wait_sig(0, 1'b1);
    rst_b = 1'b0;
    cyc(1);
    check("reset run", W'(run_q), '0);
    check("reset ref", speed_ref_q, '0);
    cyc(4);
    rst_b = 1'b1;
    cyc(2);
    check("three wire after reset", W'(three_wire_q), 16'h0001);
    check("run after reset", W'(run_q), '0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
